// [rtl/tsc_cfg.svh]
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH
`define TSC_OFS_ADC_CTRL 8'h00
`define TSC_OFS_DAC_DATA 8'h04
`define TSC_OFS_DAC_CTRL 8'h08
`define TSC_OFS_STATUS 8'h0c
`define TSC_OFS_MASK 8'h10
`define TSC_OFS_RESULT 8'h14
`define TSC_RST_CTRL 12'h000
`define TSC_RST_DAC 8'h80
`define TSC_ST_DONE 0
`define TSC_ST_PEN 1
`define TSC_ST_KEY 2
`define TSC_ST_BUSY 8
`define TSC_ST_REF 9
`define TSC_CLK_HZ 20000000
`define TSC_OSC_HZ 10000000
`define TSC_OSC_NS 100
`define TSC_ACQ_SHORT_NS 1500
`define TSC_ACQ_MID_NS 5000
`define TSC_ACQ_LONG_NS 95000
`define TSC_TICKS(ns) (((ns) + `TSC_OSC_NS - 1) / `TSC_OSC_NS)
`define TSC_CS_CONFIG 4'h0
`define TSC_CS_AUX_INPUT_1 4'h5
`define TSC_CS_TEMP 4'h9
`define TSC_CS_YPOS 4'ha
`define TSC_CS_XPOS 4'hb
`define TSC_MUX_XP 4'h0
`define TSC_MUX_YP 4'h2
`define TSC_RES_8 2'h0
`define TSC_RES_10 2'h1
`define TSC_ACQ_SHORT 2'h0
`define TSC_ACQ_MID 2'h1
`endif

// [rtl/tsc_pkg.sv]
package tsc_pkg;
    typedef enum logic [2:0] {st_idle, st_ref_up, st_acq, st_conv, st_done} tsc_state_t;
    typedef struct packed {
        logic pen_det_en;
        logic ref_mode_hi;
        logic ref_mode_lo;
        logic ref_level_select;
        logic [1:0] acq_sel;
        logic [1:0] res_sel;
        logic [3:0] conversion_select;
    } tsc_ctrl_t;
    typedef struct packed {
        logic yp_drv;
        logic yn_drv;
        logic xp_drv;
        logic xn_drv;
    } tsc_panel_t;
endpackage

// [rtl/tsc_ctrl.sv]
// How it works
// - y position: both y drivers on, x drivers off, sample x plus
// - input selector picks one of nine analog sources
// - acquisition time selectable 1.5, 5.0 or 95 us via control register
// - ref_level_select chooses 1.0 V or 2.5 V internal reference
// - ref_mode_hi zero selects internal reference, one selects external
// - reset leaves reference mode bits at zero, auto power-down
// - auto mode: aux, battery, temp scans power reference, settle, scan, off
// - full-power mode keeps internal reference powered continuously
// - 10 MHz tick times acquisition, conversion and reference settling
// - converter output code starts midscale, held until rewritten
// - converter shutdown enables the pull-down load on its output
// - busy output asserted while any operation runs
// - pen touch and key press reported on their interrupt outputs
// - registers reset to zero, converter data to 8'h80
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`include "tsc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tsc_ctrl
    import tsc_pkg::*;
#(
    parameter int unsigned OSC_DIV = `TSC_CLK_HZ / `TSC_OSC_HZ,
    parameter int unsigned SETTLE_8 = 100,
    parameter int unsigned SETTLE_10 = 200,
    parameter int unsigned SETTLE_12 = 300
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pen_touch,
    input wire logic key_press,
    input wire logic [11:0] conv_data,
    output tsc_panel_t panel,
    output logic [3:0] mux_sel,
    output logic sample,
    output logic ref_power,
    output logic ref_level_select,
    output logic ref_external,
    output logic [7:0] dac_code,
    output logic dac_pulldown,
    output logic busy_n,
    output logic pen_touch_irq_n,
    output logic key_press_irq_n,
    output logic irq
);
    if (OSC_DIV < 1 || OSC_DIV > 256 || SETTLE_8 < 1 || SETTLE_8 > 1023 || SETTLE_10 < 1
        || SETTLE_10 > 1023 || SETTLE_12 < 1 || SETTLE_12 > 1023) begin : g_bad
        $error("tsc_ctrl: unsupported parameter value");
    end

    function automatic logic [9:0] acq_ticks(input logic [1:0] s);
        unique case (s)
            `TSC_ACQ_SHORT: acq_ticks = 10'(`TSC_TICKS(`TSC_ACQ_SHORT_NS));
            `TSC_ACQ_MID: acq_ticks = 10'(`TSC_TICKS(`TSC_ACQ_MID_NS));
            default: acq_ticks = 10'(`TSC_TICKS(`TSC_ACQ_LONG_NS));
        endcase
    endfunction

    function automatic logic [9:0] settle_ticks(input logic [1:0] r);
        unique case (r)
            `TSC_RES_8: settle_ticks = 10'(SETTLE_8);
            `TSC_RES_10: settle_ticks = 10'(SETTLE_10);
            default: settle_ticks = 10'(SETTLE_12);
        endcase
    endfunction

    function automatic logic [9:0] conv_ticks(input logic [1:0] r);
        unique case (r)
            `TSC_RES_8: conv_ticks = 10'd8;
            `TSC_RES_10: conv_ticks = 10'd10;
            default: conv_ticks = 10'd12;
        endcase
    endfunction

    function automatic logic needs_ref(input logic [3:0] cs);
        needs_ref = cs >= `TSC_CS_AUX_INPUT_1 && cs <= `TSC_CS_TEMP;
    endfunction

    // osc tick divider, realigned at scan start so each interval has a fixed phase
    logic start;
    logic [7:0] div_q, div_d;
    logic tick_q, tick_d;
    always_comb begin
        tick_d = div_q == 8'(OSC_DIV - 1) && !start;
        div_d = tick_d ? 8'h00 : div_q + 8'h01;
        if (start) begin
            div_d = 8'(OSC_DIV - 1);
        end
    end
    always_ff @(posedge clock) begin
        if (!resetn) begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // register file and avalon slave
    tsc_ctrl_t ctrl_q, ctrl_d;
    logic [7:0] dac_q, dac_d;
    logic shut_q, shut_d;
    logic [2:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic wait_q, wait_d, irq_q, irq_d;
    logic pen_q, pen_d, key_q, key_d;
    logic [11:0] result_q, result_d;
    tsc_state_t st_q, st_d;
    logic wr_acc, rd_acc, done_ev;
    always_comb begin
        wr_acc = avs_write && !wait_q;
        rd_acc = avs_read && !wait_q;
        wait_d = !((avs_read || avs_write) && wait_q);
        ctrl_d = ctrl_q;
        dac_d = dac_q;
        shut_d = shut_q;
        mask_d = mask_q;
        stat_d = stat_q;
        start = 1'b0;
        pen_d = !pen_touch_irq_n;
        key_d = !key_press_irq_n;
        if (wr_acc) begin
            unique case (avs_address)
                `TSC_OFS_ADC_CTRL: begin
                    ctrl_d = tsc_ctrl_t'(avs_writedata[11:0]);
                    start = avs_writedata[3:0] != `TSC_CS_CONFIG
                        && avs_writedata[3:0] <= `TSC_CS_XPOS && st_q == st_idle;
                end
                `TSC_OFS_DAC_DATA: dac_d = avs_writedata[7:0];
                `TSC_OFS_DAC_CTRL: shut_d = avs_writedata[0];
                `TSC_OFS_MASK: mask_d = avs_writedata[2:0];
                default: ;
            endcase
        end
        rdata_d = 32'h0000_0000;
        if (avs_read && wait_q) begin
            unique case (avs_address)
                `TSC_OFS_ADC_CTRL: rdata_d = {20'h00000, ctrl_q};
                `TSC_OFS_DAC_DATA: rdata_d = {24'h000000, dac_q};
                `TSC_OFS_DAC_CTRL: rdata_d = {31'h00000000, shut_q};
                `TSC_OFS_STATUS: begin
                    rdata_d = {29'h00000000, stat_q};
                    rdata_d[`TSC_ST_BUSY] = st_q != st_idle;
                    rdata_d[`TSC_ST_REF] = ref_power;
                end
                `TSC_OFS_MASK: rdata_d = {29'h00000000, mask_q};
                `TSC_OFS_RESULT: rdata_d = {20'h00000, result_q};
                default: ;
            endcase
        end
        if (rd_acc && avs_address == `TSC_OFS_STATUS) begin
            stat_d = 3'h0;
        end
        // set beats clear
        if (done_ev) begin
            stat_d[`TSC_ST_DONE] = 1'b1;
        end
        if (!pen_q && !pen_touch_irq_n) begin
            stat_d[`TSC_ST_PEN] = 1'b1;
        end
        if (!key_q && !key_press_irq_n) begin
            stat_d[`TSC_ST_KEY] = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctrl_q <= `TSC_RST_CTRL;
            dac_q <= `TSC_RST_DAC;
            shut_q <= 1'b0;
            mask_q <= 3'h0;
            stat_q <= 3'h0;
            rdata_q <= 32'h0000_0000;
            wait_q <= 1'b1;
            irq_q <= 1'b0;
            pen_q <= 1'b0;
            key_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            dac_q <= dac_d;
            shut_q <= shut_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
            irq_q <= irq_d;
            pen_q <= pen_d;
            key_q <= key_d;
        end
    end

    // scan sequencer
    tsc_ctrl_t cfg_q, cfg_d;
    logic [9:0] cnt_q, cnt_d;
    tsc_panel_t panel_d;
    logic [3:0] mux_d;
    logic samp_d, refp_d, busy_n_d, pirq_d, kirq_d, full_pwr, auto_pwr;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        cfg_d = cfg_q;
        result_d = result_q;
        done_ev = 1'b0;
        unique case (st_q)
            st_idle: if (start) begin
                cfg_d = ctrl_d;
                if (needs_ref(ctrl_d.conversion_select) && !ctrl_d.ref_mode_hi
                    && !ctrl_d.ref_mode_lo) begin
                    st_d = st_ref_up;
                    cnt_d = settle_ticks(ctrl_d.res_sel);
                end else begin
                    st_d = st_acq;
                    cnt_d = acq_ticks(ctrl_d.acq_sel);
                end
            end
            st_ref_up: if (tick_q) begin
                cnt_d = cnt_q - 10'd1;
                if (cnt_q == 10'd1) begin
                    st_d = st_acq;
                    cnt_d = acq_ticks(cfg_q.acq_sel);
                end
            end
            st_acq: if (tick_q) begin
                cnt_d = cnt_q - 10'd1;
                if (cnt_q == 10'd1) begin
                    st_d = st_conv;
                    cnt_d = conv_ticks(cfg_q.res_sel);
                end
            end
            st_conv: if (tick_q) begin
                cnt_d = cnt_q - 10'd1;
                if (cnt_q == 10'd1) begin
                    st_d = st_done;
                    result_d = conv_data;
                end
            end
            st_done: begin
                st_d = st_idle;
                done_ev = 1'b1;
            end
        endcase
        panel_d = '0;
        // next config, so drivers and selector are right in the first acquisition cycle
        mux_d = cfg_d.conversion_select - 4'h1;
        if (cfg_d.conversion_select == `TSC_CS_YPOS) begin
            mux_d = `TSC_MUX_XP;
        end
        if (cfg_d.conversion_select == `TSC_CS_XPOS) begin
            mux_d = `TSC_MUX_YP;
        end
        if (st_d == st_acq || st_d == st_conv) begin
            if (cfg_d.conversion_select == `TSC_CS_YPOS) begin
                panel_d.yp_drv = 1'b1;
                panel_d.yn_drv = 1'b1;
            end
            if (cfg_d.conversion_select == `TSC_CS_XPOS) begin
                panel_d.xp_drv = 1'b1;
                panel_d.xn_drv = 1'b1;
            end
        end
        if (st_d == st_idle) begin
            mux_d = mux_sel;
        end
        samp_d = st_d == st_acq;
        full_pwr = !ctrl_q.ref_mode_hi && ctrl_q.ref_mode_lo;
        auto_pwr = !ctrl_q.ref_mode_hi && !ctrl_q.ref_mode_lo;
        refp_d = full_pwr
            || (auto_pwr && st_d != st_idle && st_d != st_done
                && needs_ref(cfg_d.conversion_select));
        busy_n_d = st_d == st_idle;
        pirq_d = !(pen_touch && ctrl_q.pen_det_en);
        kirq_d = !key_press;
    end
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_q <= st_idle;
            cnt_q <= 10'd0;
            cfg_q <= `TSC_RST_CTRL;
            result_q <= 12'h000;
            panel <= '0;
            mux_sel <= 4'h0;
            sample <= 1'b0;
            ref_power <= 1'b0;
            ref_level_select <= 1'b0;
            ref_external <= 1'b0;
            busy_n <= 1'b1;
            pen_touch_irq_n <= 1'b1;
            key_press_irq_n <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cfg_q <= cfg_d;
            result_q <= result_d;
            panel <= panel_d;
            mux_sel <= mux_d;
            sample <= samp_d;
            ref_power <= refp_d;
            ref_level_select <= ctrl_q.ref_level_select;
            ref_external <= ctrl_q.ref_mode_hi;
            busy_n <= busy_n_d;
            pen_touch_irq_n <= pirq_d;
            key_press_irq_n <= kirq_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq = irq_q;
    assign dac_code = dac_q;
    assign dac_pulldown = shut_q;

    // assertion helpers: ticks spent in acquisition and settling
    logic [9:0] acq_h, set_h;
    always_ff @(posedge clock) begin
        if (!resetn || !sample) acq_h <= 10'd0;
        else if (tick_q) acq_h <= acq_h + 10'd1;
        if (!resetn || st_q != st_ref_up) set_h <= 10'd0;
        else if (tick_q) set_h <= set_h + 10'd1;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    a_ypos_drive: assert property (sample && cfg_q.conversion_select == `TSC_CS_YPOS
        |-> panel == 4'b1100 && mux_sel == `TSC_MUX_XP) else $error("y drive wrong");
    a_mux_range: assert property (mux_sel <= 4'h8)
        else $error("mux out of range");
    a_acq_len: assert property ($fell(sample) |-> acq_h == acq_ticks(cfg_q.acq_sel))
        else $error("acquisition length wrong");
    a_ref_level: assert property (##1 ref_level_select == $past(ctrl_q.ref_level_select))
        else $error("ref level mismatch");
    a_ext_ref: assert property (ctrl_q.ref_mode_hi |=> !ref_power && ref_external)
        else $error("external ref with internal on");
    a_reset_mode: assert property ($rose(resetn) |-> ctrl_q == `TSC_RST_CTRL)
        else $error("reset mode wrong");
    a_auto_seq: assert property (st_q == st_ref_up && $past(st_q) == st_idle
        |-> ref_power && !sample) else $error("ref not up before scan");
    a_settle_len: assert property ($fell(st_q == st_ref_up)
        |-> set_h == settle_ticks(cfg_q.res_sel)) else $error("settle length wrong");
    a_full_power: assert property (!ctrl_q.ref_mode_hi && ctrl_q.ref_mode_lo |=> ref_power)
        else $error("full power ref off");
    a_osc_tick: assert property (tick_q |=> !tick_q)
        else $error("tick too fast");
    a_dac_reset: assert property ($rose(resetn) |-> dac_code == `TSC_RST_DAC)
        else $error("dac not midscale");
    a_busy_scan: assert property (start |=> !busy_n)
        else $error("busy missing");
    a_pen_irq: assert property (pen_touch && ctrl_q.pen_det_en |=> !pen_touch_irq_n)
        else $error("pen irq missing");
    c_aux_auto: cover property (st_q == st_ref_up ##[1:1000] st_q == st_done);
    c_ypos: cover property (sample && cfg_q.conversion_select == `TSC_CS_YPOS);
    c_stat_read: cover property (rd_acc && avs_address == `TSC_OFS_STATUS && stat_q != 3'h0);
endmodule // tsc_ctrl
`default_nettype wire

// [verif/tsc_front_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tsc_front_model (
    input wire logic busy_n,
    input wire logic touch_req,
    input wire logic key_req,
    input wire logic [11:0] value,
    output logic pen_touch,
    output logic key_press,
    output logic [11:0] conv_data
);
    // result only holds while a scan runs, inverted otherwise
    assign conv_data = busy_n ? ~value : value;
    assign pen_touch = touch_req;
    assign key_press = key_req;
endmodule // tsc_front_model
`default_nettype wire

// [verif/touch_adc_reference_sequencer_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module touch_adc_reference_sequencer_bench import tsc_pkg::*;;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pen_touch, key_press, sample, ref_power, ref_level_select, ref_external;
    logic touch_req = 1'b0;
    logic key_req = 1'b0;
    logic dac_pulldown, busy_n, pen_touch_irq_n, key_press_irq_n, irq;
    logic [11:0] conv_data;
    logic [11:0] value = 12'h0;
    logic [7:0] dac_code;
    logic [3:0] mux_sel;
    tsc_panel_t panel;
    logic [31:0] exp_q[$];
    logic [31:0] w;
    int n_mismatch = 0;
    int cmp_count = 0;
    integer seed = 32'hbd59;

    tsc_ctrl #(.SETTLE_8(3), .SETTLE_10(4), .SETTLE_12(5)) DUT (
        .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pen_touch(pen_touch), .key_press(key_press),
        .conv_data(conv_data), .panel(panel), .mux_sel(mux_sel), .sample(sample),
        .ref_power(ref_power), .ref_level_select(ref_level_select),
        .ref_external(ref_external), .dac_code(dac_code), .dac_pulldown(dac_pulldown),
        .busy_n(busy_n), .pen_touch_irq_n(pen_touch_irq_n),
        .key_press_irq_n(key_press_irq_n), .irq(irq)
    );
    tsc_front_model u_front (
        .busy_n(busy_n), .touch_req(touch_req), .key_req(key_req), .value(value),
        .pen_touch(pen_touch), .key_press(key_press), .conv_data(conv_data)
    );

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic hang();
        n_mismatch++;
        $display("unexpected at %0t: wait ran out", $time);
        final_report();
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) hang();
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        bus(1'b0, a, 32'h0);
    endtask

    // read data compared as it appears
    always @(posedge clock) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            check(avs_readdata, exp_q.pop_front());
        end
    end

    function automatic tsc_ctrl_t mk(input logic [3:0] cs, input logic [1:0] res,
                                     input logic [1:0] acq, input logic lo);
        mk = '0;
        mk.conversion_select = cs;
        mk.res_sel = res;
        mk.acq_sel = acq;
        mk.ref_mode_lo = lo;
    endfunction

    task automatic scan(input tsc_ctrl_t c, input int acq_cyc, input logic [3:0] mux_exp,
                        input logic [3:0] pan_exp, input logic ref_exp, input logic ref_after);
        int n, s;
        logic started, rs;
        logic [3:0] mseen, pseen;
        n = 0;
        s = 0;
        started = 1'b0;
        value <= 12'($random(seed));
        bus(1'b1, 8'h00, 32'(c));
        while (!(started && busy_n === 1'b1) && n < 5000) begin
            @(posedge clock);
            n++;
            if (busy_n === 1'b0) started = 1'b1;
            if (sample === 1'b1) begin
                s++;
                rs = ref_power;
                mseen = mux_sel;
                pseen = panel;
            end
        end
        if (n >= 5000) hang();
        check(s, acq_cyc);
        check(mseen, mux_exp);
        check(pseen, pan_exp);
        if (ref_exp !== 1'bx) check(rs, ref_exp);
        @(posedge clock);
        check(ref_power, ref_after);
        check(irq, 1'b1);
        rd(8'h0c, {22'h0, ref_after, 9'h001});
        rd(8'h14, {20'h0, value});
        repeat (2) @(posedge clock);
        check(irq, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check(dac_code, 8'h80);
        check({busy_n, irq, ref_power, ref_external}, 4'h8);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h80);
        rd(8'h10, 32'h0);
        rd(8'h20, 32'h0);
        w = $random(seed);
        bus(1'b1, 8'h04, {24'h0, w[7:0]});
        @(posedge clock);
        check(dac_code, w[7:0]);
        bus(1'b1, 8'h08, 32'h1);
        @(posedge clock);
        check(dac_pulldown, 1'b1);
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h00, 32'h100);
        repeat (2) @(posedge clock);
        check(ref_level_select, 1'b1);
        bus(1'b1, 8'h00, 32'h400);
        repeat (2) @(posedge clock);
        check({ref_external, ref_power}, 2'b10);
        bus(1'b1, 8'h00, 32'h000);
        bus(1'b1, 8'h10, 32'h7);
        for (int k = 1; k <= 9; k++) begin
            scan(mk(4'(k), 2'h0, 2'h0, 1'b0), 30, 4'(k - 1), 4'h0,
                 (k >= 5) ? 1'b1 : 1'b0, 1'b0);
        end
        scan(mk(4'h5, 2'h1, 2'h1, 1'b0), 100, 4'h4, 4'h0, 1'b1, 1'b0);
        scan(mk(4'h6, 2'h2, 2'h2, 1'b0), 1900, 4'h5, 4'h0, 1'b1, 1'b0);
        scan(mk(4'ha, 2'h0, 2'h0, 1'b0), 30, 4'h0, 4'hc, 1'b0, 1'b0);
        scan(mk(4'hb, 2'h0, 2'h0, 1'b0), 30, 4'h2, 4'h3, 1'b0, 1'b0);
        scan(mk(4'h9, 2'h0, 2'h1, 1'b1), 100, 4'h8, 4'h0, 1'b1, 1'b1);
        bus(1'b1, 8'h00, 32'h800);
        bus(1'b1, 8'h10, 32'h1);
        touch_req <= 1'b1;
        key_req <= 1'b1;
        repeat (3) @(posedge clock);
        check({pen_touch_irq_n, key_press_irq_n}, 2'b00);
        check(irq, 1'b0);
        touch_req <= 1'b0;
        key_req <= 1'b0;
        repeat (3) @(posedge clock);
        check({pen_touch_irq_n, key_press_irq_n}, 2'b11);
        rd(8'h0c, 32'h6);
        rd(8'h0c, 32'h0);
        final_report();
    end
endmodule // touch_adc_reference_sequencer_bench
`default_nettype wire
